/* hw/pwmt_top.sv */
// Timer/counter with seven matches, two captures and six modulated outputs
`timescale 1ns/1ps
`include "pwmt_consts.svh"

module pwmt_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  cap_in,
   input  wire logic        sync_en_in,
   output logic             sync_en_out,
   output logic      [6:1]  pwm_out,
   output logic      [6:0]  match_out,
   output logic             irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [31:0] tc_r, pc_r, pr_r, prdata_r, rd_nxt;
   logic [31:0] mr_r     [7];
   logic [31:0] mr_act_r [7];
   logic [31:0] cr_r     [2];
   logic [6:0]  ctrl_r, ler_r, ext_r, match, m_int, m_rst, m_stp;
   logic [20:0] mcr_r;
   logic [5:0]  ccr_r;
   logic [13:0] emr_r, pcr_r;
   logic [8:0]  ir_r, ir_set;
   logic [6:1]  pq_r;
   logic [1:0]  cap_s1, cap_s2, cap_s3, cap_rise, cap_fall, cap_ev;
   logic        wr, run, src, adv, any_rst, any_stp, restart;
   pwmt_pkg::pwmt_cnt_mode_t mode;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // True when addr falls on one of n words starting at base
   function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base, input int n);
      in_bank = (addr >= base) && (addr < 8'(base + 8'(4 * n))) && (addr[1:0] == 2'h0);
   endfunction : in_bank

   // Word index within a bank
   function automatic logic [2:0] bank_idx(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] d;
      d = addr - base;
      bank_idx = d[4:2];
   endfunction : bank_idx

   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;                      // Zero wait states
   assign pslverr = psel & penable & ((paddr > `PWMT_OFF_LAST) | (paddr[1:0] != 2'h0));
   assign prdata  = prdata_r;

   // ----------------------------------------
   // Count source and prescaler
   // ----------------------------------------
   // Capture pins pass two flops; third flop feeds edge detection only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_s1 <= 2'h0;
         cap_s2 <= 2'h0;
         cap_s3 <= 2'h0;
      end else begin
         cap_s1 <= cap_in;
         cap_s2 <= cap_s1;
         cap_s3 <= cap_s2;
      end
   end

   assign cap_rise = cap_s2 & ~cap_s3;
   assign cap_fall = ~cap_s2 & cap_s3;
   assign mode     = pwmt_pkg::pwmt_cnt_mode_t'(ctrl_r[`PWMT_CTRL_MODE+:2]);
   // Counter mode counts the chosen edges of one capture pin
   assign src = (mode == pwmt_pkg::PWMT_CNT_TIMER) ? 1'b1 :
                (mode[0] & cap_rise[ctrl_r[`PWMT_CTRL_CSEL]]) |
                (mode[1] & cap_fall[ctrl_r[`PWMT_CTRL_CSEL]]);
   // Slave follows the master's enable so both start on one edge
   assign run = ctrl_r[`PWMT_CTRL_SLAVE] ? sync_en_in : ctrl_r[`PWMT_CTRL_EN];
   assign sync_en_out = ctrl_r[`PWMT_CTRL_EN];
   assign adv = run & ~ctrl_r[`PWMT_CTRL_RST] & src & (pc_r == pr_r);

   // ----------------------------------------
   // Match decode
   // ----------------------------------------
   // Match fires as the counter leaves the matching value, so a reset
   // on match zero gives a cycle of that value plus one counts
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_match
         assign match[gi] = adv & (tc_r == mr_act_r[gi]);
         assign m_int[gi] = mcr_r[3*gi];
         assign m_rst[gi] = mcr_r[3*gi+1];
         assign m_stp[gi] = mcr_r[3*gi+2];
      end
   endgenerate
   assign any_rst = |(match & m_rst);
   assign any_stp = |(match & m_stp);
   assign restart = match[0] & m_rst[0];

   // ----------------------------------------
   // Counter and prescale counter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_r <= `PWMT_RST_WORD;
         pc_r <= `PWMT_RST_WORD;
      end else if (ctrl_r[`PWMT_CTRL_RST]) begin
         tc_r <= `PWMT_RST_WORD;
         pc_r <= `PWMT_RST_WORD;
      end else if (run & src) begin
         if (pc_r == pr_r) begin
            pc_r <= `PWMT_RST_WORD;
            tc_r <= any_rst ? `PWMT_RST_WORD : tc_r + 32'h0000_0001;
         end else begin
            pc_r <= pc_r + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   // A stop match wins over a write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 7'h00;
         pr_r   <= `PWMT_RST_WORD;
         mcr_r  <= 21'h00_0000;
         ccr_r  <= 6'h00;
         emr_r  <= 14'h0000;
         pcr_r  <= 14'h0000;
      end else begin
         if (wr && paddr == `PWMT_OFF_CTRL) ctrl_r <= pwdata[6:0];
         if (wr && paddr == `PWMT_OFF_PR)   pr_r   <= pwdata;
         if (wr && paddr == `PWMT_OFF_MCR)  mcr_r  <= pwdata[20:0];
         if (wr && paddr == `PWMT_OFF_CCR)  ccr_r  <= pwdata[5:0];
         if (wr && paddr == `PWMT_OFF_EMR)  emr_r  <= pwdata[13:0];
         if (wr && paddr == `PWMT_OFF_PCR)  pcr_r  <= pwdata[13:0];
         if (any_stp) ctrl_r[`PWMT_CTRL_EN] <= 1'b0;
      end
   end

   // Release bits clear at restart; a new write in that cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ler_r <= 7'h00;
      end else if (wr && paddr == `PWMT_OFF_LER) begin
         ler_r <= pwdata[6:0];
      end else if (restart) begin
         ler_r <= 7'h00;
      end
   end

   // ----------------------------------------
   // Match shadows
   // ----------------------------------------
   // In PWM mode active values change only at a cycle restart with the release bit set, so no pulse is torn; otherwise they follow every cycle
   generate
      for (gi = 0; gi < 7; gi++) begin : g_mr
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mr_r[gi]     <= `PWMT_RST_WORD;
               mr_act_r[gi] <= `PWMT_RST_WORD;
            end else begin
               if (wr && in_bank(paddr, `PWMT_OFF_MR0, 7) && bank_idx(paddr, `PWMT_OFF_MR0) == 3'(gi))
                  mr_r[gi] <= pwdata;
               if (!ctrl_r[`PWMT_CTRL_PWM] || (restart && ler_r[gi]))
                  mr_act_r[gi] <= mr_r[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Capture
   // ----------------------------------------
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cap
         assign cap_ev[gi] = (cap_rise[gi] & ccr_r[3*gi]) | (cap_fall[gi] & ccr_r[3*gi+1]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) cr_r[gi] <= `PWMT_RST_WORD;
            else if (cap_ev[gi]) cr_r[gi] <= tc_r;
         end
         assign ir_set[`PWMT_IR_CAP+gi] = cap_ev[gi] & ccr_r[3*gi+2];
      end
   endgenerate

   // ----------------------------------------
   // Event flags
   // ----------------------------------------
   // Write one to clear; a fresh event beats the clear
   assign ir_set[6:0] = match & m_int;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ir_r <= 9'h000;
      else ir_r <= (ir_r & ~((wr && paddr == `PWMT_OFF_IR) ? pwdata[8:0] : 9'h000)) | ir_set;
   end
   assign irq = |ir_r;

   // ----------------------------------------
   // External match outputs
   // ----------------------------------------
   generate
      for (gi = 0; gi < 7; gi++) begin : g_ext
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ext_r[gi] <= `PWMT_RST_BIT;
            end else if (match[gi]) begin
               case (pwmt_pkg::pwmt_em_act_t'(emr_r[2*gi+:2]))
                  pwmt_pkg::PWMT_EM_LOW:    ext_r[gi] <= 1'b0;
                  pwmt_pkg::PWMT_EM_HIGH:   ext_r[gi] <= 1'b1;
                  pwmt_pkg::PWMT_EM_TOGGLE: ext_r[gi] <= ~ext_r[gi];
                  default:                  ext_r[gi] <= ext_r[gi];
               endcase
            end
         end
      end
   endgenerate
   assign match_out = ext_r;

   // ----------------------------------------
   // Modulated outputs
   // ----------------------------------------
   // Output n falls on match n; it rises on match zero when single-edged
   // or on match n-1 when double-edged. Fall wins a tie, so a fall match
   // equal to match zero holds a single-edge output constantly low.
   generate
      for (gi = 1; gi < 7; gi++) begin : g_pwm
         logic set_e;
         assign set_e = (gi >= 2 && pcr_r[gi]) ? match[gi-1] : match[0];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) pq_r[gi] <= `PWMT_RST_BIT;
            else if (match[gi]) pq_r[gi] <= 1'b0;
            else if (set_e) pq_r[gi] <= 1'b1;
         end
         assign pwm_out[gi] = pq_r[gi] & pcr_r[`PWMT_PCR_ENA+gi] & ctrl_r[`PWMT_CTRL_PWM];
      end
   endgenerate

   // ----------------------------------------
   // Read data, captured in the setup phase
   // ----------------------------------------
   always_comb begin
      rd_nxt = `PWMT_RST_WORD;
      case (paddr)
         `PWMT_OFF_CTRL: rd_nxt = {25'h000_0000, ctrl_r};
         `PWMT_OFF_TC:   rd_nxt = tc_r;
         `PWMT_OFF_PR:   rd_nxt = pr_r;
         `PWMT_OFF_PC:   rd_nxt = pc_r;
         `PWMT_OFF_MCR:  rd_nxt = {11'h000, mcr_r};
         `PWMT_OFF_CCR:  rd_nxt = {26'h000_0000, ccr_r};
         `PWMT_OFF_EMR:  rd_nxt = {11'h000, ext_r, emr_r};
         `PWMT_OFF_PCR:  rd_nxt = {18'h0_0000, pcr_r};
         `PWMT_OFF_LER:  rd_nxt = {25'h000_0000, ler_r};
         `PWMT_OFF_IR:   rd_nxt = {23'h00_0000, ir_r};
         default: begin
            if (in_bank(paddr, `PWMT_OFF_MR0, 7)) rd_nxt = mr_r[bank_idx(paddr, `PWMT_OFF_MR0)];
            else if (in_bank(paddr, `PWMT_OFF_CR0, 2)) rd_nxt = cr_r[bank_idx(paddr, `PWMT_OFF_CR0) == 3'h1];
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_r <= `PWMT_RST_WORD;
      else if (psel && !penable && !pwrite) prdata_r <= rd_nxt;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_prescale;
      run && !ctrl_r[`PWMT_CTRL_RST] && src && pc_r != pr_r |=> pc_r == $past(pc_r) + 32'h1 && $stable(tc_r);
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler step wrong");

   property p_tc_step;
      adv && !any_rst |=> tc_r == $past(tc_r) + 32'h1 && pc_r == 32'h0;
   endproperty
   a_tc_step: assert property (p_tc_step) else $error("counter did not advance");

   property p_cnt_hold;
      mode != pwmt_pkg::PWMT_CNT_TIMER && !src && !ctrl_r[`PWMT_CTRL_RST] |=> $stable(tc_r) && $stable(pc_r);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counted without edge");

   property p_restart;
      restart && !ctrl_r[`PWMT_CTRL_RST] |=> tc_r == 32'h0 && pc_r == 32'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("cycle match did not reset");

   property p_stop;
      any_stp |=> !ctrl_r[`PWMT_CTRL_EN];
   endproperty
   a_stop: assert property (p_stop) else $error("stop match left enable set");

   property p_flag;
      match[0] && m_int[0] |=> ir_r[0];
   endproperty
   a_flag: assert property (p_flag) else $error("match flag lost");

   property p_rise1;
      match[0] && !match[1] |=> pq_r[1];
   endproperty
   a_rise1: assert property (p_rise1) else $error("single edge did not rise");

   property p_fall1;
      match[1] |=> !pq_r[1];
   endproperty
   a_fall1: assert property (p_fall1) else $error("single edge did not fall");

   property p_dbl;
      pcr_r[2] && match[1] && !match[2] |=> pq_r[2] && !pq_r[1];
   endproperty
   a_dbl: assert property (p_dbl) else $error("double edge rise wrong");

   property p_release;
      ctrl_r[`PWMT_CTRL_PWM] && !restart |=> $stable(mr_act_r[1]);
   endproperty
   a_release: assert property (p_release) else $error("match value applied mid-cycle");

   property p_off;
      !ctrl_r[`PWMT_CTRL_PWM] |-> pwm_out == 6'h00;
   endproperty
   a_off: assert property (p_off) else $error("modulated output while disabled");

   property p_capture;
      cap_ev[0] |=> cr_r[0] == $past(tc_r);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_toggle;
      match[0] && emr_r[1:0] == 2'h3 |=> ext_r[0] != $past(ext_r[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("match output did not toggle");

   c_restart: cover property (restart ##1 tc_r == 32'h0);
   c_capture: cover property (cap_ev[1]);
   c_pwm_hi:  cover property (pwm_out[1] ##1 !pwm_out[1]);
endmodule : pwmt_top

/* hw/pwmt_consts.svh */
// Register offsets, field positions and reset values of the modulating timer
`ifndef PWMT_CONSTS_SVH
`define PWMT_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWMT_OFF_CTRL 8'h00
`define PWMT_OFF_TC   8'h04
`define PWMT_OFF_PR   8'h08
`define PWMT_OFF_PC   8'h0C
`define PWMT_OFF_MCR  8'h10
`define PWMT_OFF_CCR  8'h14
`define PWMT_OFF_EMR  8'h18
`define PWMT_OFF_PCR  8'h1C
`define PWMT_OFF_LER  8'h20
`define PWMT_OFF_IR   8'h24
`define PWMT_OFF_MR0  8'h28
`define PWMT_OFF_CR0  8'h44
`define PWMT_OFF_LAST 8'h48
// ----------------------------------------
// Control, PCR and IR field positions
// ----------------------------------------
`define PWMT_CTRL_EN    0
`define PWMT_CTRL_RST   1
`define PWMT_CTRL_PWM   2
`define PWMT_CTRL_MODE  3
`define PWMT_CTRL_CSEL  5
`define PWMT_CTRL_SLAVE 6
`define PWMT_PCR_ENA    7
`define PWMT_IR_CAP     7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWMT_RST_WORD 32'h0000_0000
`define PWMT_RST_BIT  1'h0
`endif

/* hw/pwmt_pkg.sv */
// Shared types of the modulating timer
package pwmt_pkg;
   // Count source select: bit 0 counts rising, bit 1 falling edges
   typedef enum logic [1:0] {
      PWMT_CNT_TIMER = 2'h0,
      PWMT_CNT_RISE  = 2'h1,
      PWMT_CNT_BOTH  = 2'h3,
      PWMT_CNT_FALL  = 2'h2
   } pwmt_cnt_mode_t;
   // Action of an external match output on its match
   typedef enum logic [1:0] {
      PWMT_EM_HOLD   = 2'h0,
      PWMT_EM_LOW    = 2'h1,
      PWMT_EM_HIGH   = 2'h2,
      PWMT_EM_TOGGLE = 2'h3
   } pwmt_em_act_t;
endpackage : pwmt_pkg

/* tb/pwmt_load.sv */
// Load model on the modulated outputs: counts high cycles in a window
`timescale 1ns/1ps

module pwmt_load (
   input  wire logic             pclk,
   input  wire logic             win,
   input  wire logic [6:1]       pwm_out,
   output logic      [6:1][15:0] hi_cnt
);
   logic win_q;

   // Window edge tracker
   always_ff @(posedge pclk) begin
      win_q <= win;
   end

   // High-time integrator, restarts at each window; the phase of the cycle matters unless the window spans whole periods
   always_ff @(posedge pclk) begin
      for (int i = 1; i <= 6; i++) begin
         if (win && !win_q) begin
            hi_cnt[i] <= {15'h0000, pwm_out[i]};
         end else if (win) begin
            hi_cnt[i] <= hi_cnt[i] + {15'h0000, pwm_out[i]};
         end
      end
   end
endmodule : pwmt_load

/* tb/tb.sv */
// Self-checking bench of the modulating timer
`timescale 1ns/1ps
`include "pwmt_consts.svh"

module tb;
   logic             pclk = 1'b0;
   logic             presetn = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic [1:0]       cap_in = 2'h0;
   logic             sync_en_in = 1'b0;
   logic             sync_en_out;
   logic [6:1]       pwm_out;
   logic [6:0]       match_out;
   logic             irq;
   logic [6:1][15:0] hi_cnt;
   logic             win = 1'b0;
   logic             last_err;
   logic             p;
   logic [31:0]      q;
   logic [31:0]      t1;
   logic [31:0]      t2;
   int               err_total = 0;
   int               num_checks = 0;
   int               cyc = 0;
   int               mr0, a, b, pr, n;
   integer           seed = 23;
   pwmt_pkg::pwmt_em_act_t acts [4] = '{pwmt_pkg::PWMT_EM_HIGH, pwmt_pkg::PWMT_EM_HOLD,
                                        pwmt_pkg::PWMT_EM_LOW, pwmt_pkg::PWMT_EM_HOLD};

   always #25 pclk = ~pclk;

   pwmt_top i_pwmt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
      .sync_en_in(sync_en_in), .sync_en_out(sync_en_out), .pwm_out(pwm_out), .match_out(match_out), .irq(irq));

   pwmt_load i_pwmt_load (.pclk(pclk), .win(win), .pwm_out(pwm_out), .hi_cnt(hi_cnt));

   // ----------------------------------------
   // Bus and checking helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rq);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rq = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'b1, ad, d, dummy);
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] rq);
      apb(1'b0, ad, 32'h0, rq);
   endtask : rd

   // Window of n cycles over which the load integrates high time
   task automatic measure(input int nc);
      win <= 1'b1;
      repeat (nc) @(posedge pclk);
      win <= 1'b0;
      @(posedge pclk);
   endtask : measure

   // High cycles over two periods: single edge or double edge output
   function automatic logic [31:0] exp_hi(input int m0, input int ra, input int fb, input int ps, input bit dbl);
      int h;
      h = dbl ? ((fb > ra) ? fb - ra : m0 + 1 - (ra - fb)) : ra + 1;
      return 32'(h * (ps + 1) * 2);
   endfunction : exp_hi

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int o = 0; o <= 'h48; o += 4) begin
         if (o != 'h20) begin
            rd(8'(o), q);
            chk("reset word", q, 32'h0);
         end
      end
      rd(8'h4C, q);
      chk("unmapped error", {31'h0, last_err}, 32'h1);
      chk("unmapped data", q, 32'h0);
      wr(`PWMT_OFF_TC, 32'h1234);
      rd(`PWMT_OFF_TC, q);
      chk("counter read only", q, 32'h0);
      $display("test registers done");
      // Single output 1 and double output 2 share match 1
      wr(`PWMT_OFF_MCR, 32'h2);
      wr(`PWMT_OFF_PCR, 32'h304);
      wr(`PWMT_OFF_CTRL, 32'h5);
      for (int t = 0; t < 8; t++) begin
         if (t == 0) begin
            mr0 = 7; a = 6; b = 1; pr = 0;
         end else if (t == 1) begin
            mr0 = 4; a = 1; b = 3; pr = 2;
         end else begin
            mr0 = 4 + int'($unsigned($random(seed)) % 12);
            a = 1 + int'($unsigned($random(seed)) % (mr0 - 1));
            do b = 1 + int'($unsigned($random(seed)) % (mr0 - 1)); while (b == a);
            pr = int'($unsigned($random(seed)) % 3);
         end
         // Hold the counter in reset while the prescale limit moves, so the
         // prescale count can never sit above a smaller new limit and run away
         wr(`PWMT_OFF_CTRL, 32'h7);
         wr(`PWMT_OFF_PR, 32'(pr));
         wr(`PWMT_OFF_MR0, 32'(mr0));
         wr(`PWMT_OFF_MR0 + 8'h04, 32'(a));
         wr(`PWMT_OFF_MR0 + 8'h08, 32'(b));
         wr(`PWMT_OFF_LER, 32'h7);
         wr(`PWMT_OFF_CTRL, 32'h5);
         repeat (120) @(posedge pclk);
         measure((mr0 + 1) * (pr + 1) * 2);
         chk("single edge high", 32'(hi_cnt[1]), exp_hi(mr0, a, b, pr, 1'b0));
         chk("double edge high", 32'(hi_cnt[2]), exp_hi(mr0, a, b, pr, 1'b1));
         // Unreleased value must leave both outputs untouched
         wr(`PWMT_OFF_MR0 + 8'h04, 32'h0);
         repeat (60) @(posedge pclk);
         measure((mr0 + 1) * (pr + 1) * 2);
         chk("held single", 32'(hi_cnt[1]), exp_hi(mr0, a, b, pr, 1'b0));
         chk("held double", 32'(hi_cnt[2]), exp_hi(mr0, a, b, pr, 1'b1));
      end
      $display("test modulation done");
      // ----------------------------------------
      // Plain timer, stop, capture, counting, slave
      // ----------------------------------------
      wr(`PWMT_OFF_CTRL, 32'h3);
      wr(`PWMT_OFF_PR, 32'h0);
      wr(`PWMT_OFF_MR0, 32'h7);
      wr(`PWMT_OFF_MR0 + 8'h04, 32'h1);
      wr(`PWMT_OFF_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      chk("outputs off", {26'h0, pwm_out}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`PWMT_OFF_EMR, {28'h0, acts[i], 2'h0});
         repeat (20) @(posedge pclk);
         chk("match action", {31'h0, match_out[1]}, (i < 2) ? 32'h1 : 32'h0);
      end
      wr(`PWMT_OFF_EMR, 32'h3);
      // Skip the edge that still used the old action
      @(posedge pclk);
      n = 0;
      p = match_out[0];
      repeat (32) begin
         @(posedge pclk);
         if (match_out[0] !== p) n++;
         p = match_out[0];
      end
      chk("toggle count", 32'(n), 32'h4);
      chk("sync out", {31'h0, sync_en_out}, 32'h1);
      wr(`PWMT_OFF_IR, 32'h1FF);
      wr(`PWMT_OFF_MCR, 32'h5);
      repeat (20) @(posedge pclk);
      rd(`PWMT_OFF_CTRL, q);
      chk("stopped", {31'h0, q[0]}, 32'h0);
      chk("match irq", {31'h0, irq}, 32'h1);
      rd(`PWMT_OFF_TC, t1);
      repeat (5) @(posedge pclk);
      rd(`PWMT_OFF_TC, t2);
      chk("frozen count", t2, t1);
      wr(`PWMT_OFF_IR, 32'h1FF);
      @(posedge pclk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(`PWMT_OFF_CCR, 32'h5);
      cap_in[0] <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(`PWMT_OFF_CR0, q);
      chk("capture value", q, t1);
      rd(`PWMT_OFF_IR, q);
      chk("capture flag", {31'h0, q[7]}, 32'h1);
      cap_in[0] <= 1'b0;
      wr(`PWMT_OFF_IR, 32'h1FF);
      wr(`PWMT_OFF_MCR, 32'h0);
      wr(`PWMT_OFF_CCR, 32'h0);
      // Rising edges of pin 0, then both edges of pin 1
      for (int k = 0; k < 2; k++) begin
         wr(`PWMT_OFF_CTRL, 32'h2);
         wr(`PWMT_OFF_CTRL, (k == 1) ? 32'h39 : 32'h9);
         repeat (5) begin
            cap_in[k] <= 1'b1;
            repeat (4) @(posedge pclk);
            cap_in[k] <= 1'b0;
            repeat (4) @(posedge pclk);
         end
         repeat (6) @(posedge pclk);
         rd(`PWMT_OFF_TC, q);
         chk("edge count", q, (k == 1) ? 32'hA : 32'h5);
      end
      // Slave runs only while the master enable is high
      wr(`PWMT_OFF_CTRL, 32'h2);
      wr(`PWMT_OFF_CTRL, 32'h40);
      rd(`PWMT_OFF_TC, t1);
      repeat (5) @(posedge pclk);
      rd(`PWMT_OFF_TC, t2);
      chk("slave idle", t2, t1);
      sync_en_in <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(`PWMT_OFF_TC, q);
      chk("slave runs", {31'h0, q > t2}, 32'h1);
      $display("test timer done");
      end_sim();
   end
endmodule : tb
